// ===== bus_integrity_pkg.sv
// Purpose: shared constants, register map and check-bit helpers
// Assumes: one bus clock, even parity on asserted-high levels
// Notes:   check-bit columns are odd-weight, so any single flip is located
package bus_integrity_pkg;
  // ----------------------------------------------------------------------
  // bus field layout
  // ----------------------------------------------------------------------
  localparam int          ADDR_HI       = 35;
  localparam int          ADDR_LO       = 3;
  localparam int          AP_LO_TOP     = 23;
  localparam int          AP_HI_BOT     = 24;
  localparam int          AP_HI_TOP_4G  = 31;
  localparam int          CMD_W         = 5;
  localparam int          RS_W          = 3;
  localparam int          DATA_W        = 64;
  localparam int          CHK_W         = 8;
  localparam int          CMD_WRITE_BIT = 0;
  localparam logic [1:0]  ASZ_4G        = 2'h0;
  localparam logic [2:0]  RS_IDLE       = 3'h0;
  localparam logic [2:0]  RS_DONE       = 3'h1;
  // ----------------------------------------------------------------------
  // timing and limits
  // ----------------------------------------------------------------------
  localparam logic [2:0]  ERR_PHASE     = 3'h3;
  localparam int          RETRY_LIMIT   = 1;
  localparam logic [7:0]  MC_VECTOR     = 8'h12;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_CFG       = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_CLEAR     = 8'h08;
  localparam logic [7:0]  OFS_ENABLE    = 8'h0C;
  localparam logic [7:0]  OFS_LOG       = 8'h10;
  localparam int          CFG_W         = 8;
  localparam int          ST_W          = 8;
  localparam int          CF_ADDRESS_ERROR_FLAG_DRV   = 0;
  localparam int          CF_ADDRESS_ERROR_FLAG_OBS   = 1;
  localparam int          CF_RP_CHK     = 2;
  localparam int          CF_AP_CHK     = 3;
  localparam int          CF_RSP_CHK    = 4;
  localparam int          CF_ECC        = 5;
  localparam int          CF_SNOOP_FE   = 6;
  localparam int          CF_MCE        = 7;
  localparam int          ST_RE         = 0;
  localparam int          ST_UE         = 1;
  localparam int          ST_FE         = 2;
  localparam int          ST_ADDR_PAR   = 3;
  localparam int          ST_RSP_PAR    = 4;
  localparam int          ST_DATA_CORR  = 5;
  localparam int          ST_DATA_BAD   = 6;
  localparam int          ST_SNOOP      = 7;

  typedef enum logic [1:0] {
    LINE_I = 2'h0, LINE_S = 2'h1, LINE_E = 2'h2, LINE_M = 2'h3
  } line_state_t;

  // ----------------------------------------------------------------------
  // check-bit code
  // ----------------------------------------------------------------------
  function automatic logic [CHK_W-1:0] ecc_col(input int idx);
    int n;
    logic [CHK_W-1:0] c;
    n = 0;
    c = '0;
    for (int v = 0; v < 256; v++) begin
      if ($countones(v[7:0]) inside {3, 5}) begin
        if (n == idx) c = v[7:0];
        n++;
      end
    end
    return c;
  endfunction : ecc_col

  function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) if (d[i]) c ^= ecc_col(i);
    return c;
  endfunction : ecc_gen

  function automatic logic [DATA_W-1:0] ecc_flip(input logic [CHK_W-1:0] syn);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) if (ecc_col(i) == syn) m[i] = 1'b1;
    return m;
  endfunction : ecc_flip
endpackage : bus_integrity_pkg

// ===== bus_link_if.sv
// Purpose: bus between the checking agent and the far agent
// Assumes: all lines asserted high here; polarity lives at the pads
// Notes:   address_error_flag is wired-OR of both enabled drivers
`timescale 1ns/1ns
`default_nettype none
interface bus_link_if import bus_integrity_pkg::*; ;
  logic                   request_strobe;
  logic [CMD_W-1:0]       request_command;
  logic                   request_parity;
  logic [ADDR_HI:ADDR_LO] address;
  logic [1:0]             address_size_code;
  logic [1:0]             address_parity;
  logic [RS_W-1:0]        response_status;
  logic                   response_parity;
  logic                   wr_valid;
  logic [DATA_W-1:0]      wr_data;
  logic [CHK_W-1:0]       wr_data_check_bits;
  logic                   rd_valid;
  logic [DATA_W-1:0]      rd_data;
  logic [CHK_W-1:0]       rd_data_check_bits;
  logic                   dev_address_error_flag_out;
  logic                   dev_address_error_flag_oe;
  logic                   oth_address_error_flag_out;
  logic                   oth_address_error_flag_oe;
  logic                   address_error_flag;
  logic                   error_report;
  logic                   dev_fatal;
  logic                   oth_fatal;

  assign address_error_flag = (dev_address_error_flag_oe & dev_address_error_flag_out) | (oth_address_error_flag_oe & oth_address_error_flag_out);

  modport agent (
    output request_strobe, request_command, request_parity, address,
    output address_size_code, address_parity, wr_valid, wr_data, wr_data_check_bits,
    output dev_address_error_flag_out, dev_address_error_flag_oe, error_report, dev_fatal,
    input  response_status, response_parity, rd_valid, rd_data, rd_data_check_bits,
    input  address_error_flag, oth_fatal
  );
  modport far (
    input  request_strobe, request_command, request_parity, address,
    input  address_size_code, address_parity, wr_valid, wr_data, wr_data_check_bits,
    input  address_error_flag, error_report, dev_fatal,
    output response_status, response_parity, rd_valid, rd_data, rd_data_check_bits,
    output oth_address_error_flag_out, oth_address_error_flag_oe, oth_fatal
  );
endinterface : bus_link_if
`default_nettype wire

// ===== bus_far_agent.sv
// Purpose: far end: target, parity checker and central-agent reporting
// Assumes: same clock as the checking agent, no synchronisers needed
// Notes:   inject inputs corrupt driven lines for diagnostics
`timescale 1ns/1ns
`default_nettype none
module bus_far_agent
  import bus_integrity_pkg::*;
(
  bus_link_if.far                bus,
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              address_error_flag_drive_en,
  input  wire logic              address_error_flag_observe_en,
  input  wire logic              central_nmi_en,
  input  wire logic              handler_sel,
  input  wire logic [DATA_W-1:0] rd_source,
  input  wire logic              inj_rsp_parity,
  input  wire logic [DATA_W-1:0] inj_data_flip,
  output logic                   wr_out_valid,
  output logic [DATA_W-1:0]      wr_out_data,
  output logic                   nmi,
  output logic                   soft_init
);
  typedef enum logic [3:0] {
    O_IDLE = 4'b0001, O_ERR = 4'b0010, O_WDATA = 4'b0100, O_RESP = 4'b1000
  } far_state_t;

  far_state_t        state;
  logic [2:0]        cnt;
  logic              is_write;
  logic              par_err;
  logic [CHK_W-1:0]  syn;
  logic [DATA_W-1:0] flip;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  wire rp_bad  = ^{bus.request_strobe, bus.request_command, bus.request_parity};
  wire ap0_bad = ^{bus.address[AP_LO_TOP:ADDR_LO], bus.address_parity[0]};
  wire ap1_bad = (bus.address_size_code == ASZ_4G) ?
                 ^{bus.address[AP_HI_TOP_4G:AP_HI_BOT], bus.address_parity[1]} :
                 ^{bus.address[ADDR_HI:AP_HI_BOT], bus.address_parity[1]};
  wire err_now = bus.request_strobe & (rp_bad | ap0_bad | ap1_bad);
  wire fatal   = bus.dev_fatal | bus.oth_fatal;
  wire at_err  = (state == O_ERR) && (cnt == ERR_PHASE);
  wire cancel  = at_err & bus.address_error_flag & address_error_flag_observe_en;
  assign syn   = ecc_gen(bus.wr_data) ^ bus.wr_data_check_bits;
  assign flip  = ecc_flip(syn);
  wire w_ok    = (syn == '0) | ((^syn) & ((flip != '0) | ($countones(syn) == 1)));

  assign bus.oth_address_error_flag_out = 1'b1;
  assign bus.oth_address_error_flag_oe  = at_err & par_err & address_error_flag_drive_en;

  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                  <= O_IDLE;
      cnt                    <= '0;
      is_write               <= 1'b0;
      par_err                <= 1'b0;
      bus.response_status    <= RS_IDLE;
      bus.response_parity    <= 1'b0;
      bus.rd_valid           <= 1'b0;
      bus.rd_data            <= '0;
      bus.rd_data_check_bits <= '0;
      bus.oth_fatal          <= 1'b0;
      wr_out_valid           <= 1'b0;
      wr_out_data            <= '0;
      nmi                    <= 1'b0;
      soft_init              <= 1'b0;
    end else begin
      bus.response_status <= RS_IDLE;
      bus.response_parity <= 1'b0;
      bus.rd_valid        <= 1'b0;
      bus.oth_fatal       <= 1'b0;
      wr_out_valid        <= 1'b0;
      nmi       <= (central_nmi_en & bus.address_error_flag) | (bus.error_report & !handler_sel);
      soft_init <= bus.error_report & handler_sel;
      cnt       <= cnt + 3'h1;
      case (state)
        O_IDLE: begin
          if (bus.request_strobe) begin
            state    <= O_ERR;
            cnt      <= 3'h1;
            par_err  <= err_now;
            is_write <= bus.request_command[CMD_WRITE_BIT];
          end
        end
        O_ERR: begin
          if (cancel) state <= O_IDLE;
          else if (at_err) state <= is_write ? O_WDATA : O_RESP;
          if (at_err && !cancel && !is_write) begin
            bus.response_status    <= RS_DONE;
            bus.response_parity    <= ^RS_DONE ^ inj_rsp_parity;
            bus.rd_valid           <= 1'b1;
            bus.rd_data            <= rd_source ^ inj_data_flip;
            bus.rd_data_check_bits <= ecc_gen(rd_source);
          end
        end
        O_WDATA: begin
          if (bus.wr_valid) begin
            if (!w_ok) begin
              bus.oth_fatal <= 1'b1;
              state         <= O_IDLE;
            end else begin
              wr_out_valid           <= 1'b1;
              wr_out_data            <= bus.wr_data ^ flip;
              state                  <= O_RESP;
              bus.response_status    <= RS_DONE;
              bus.response_parity    <= ^RS_DONE ^ inj_rsp_parity;
            end
          end
        end
        O_RESP: state <= O_IDLE;
        default: state <= O_IDLE;
      endcase
      if (fatal) state <= O_IDLE;
    end
  end
endmodule : bus_far_agent
`default_nettype wire

// ===== bus_error_checker.sv
// Purpose: initiating agent with request, response and data checking
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   power-on configuration is the reset value of the config register
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - classify errors recoverable, unrecoverable or fatal
// - may report errors more severely than required
// - eight check bits, single correct, double detect
// - request parity and response parity coverage
// - two address parity bits, split by size
// - driver disabled: ignore request parity errors
// - driver only: assert address error flag
// - observe with driver enabled: reset arbiter, cancel transaction next clock
// - first address error recoverable, retry once
// - response parity error is fatal
// - data checking selectable none or ECC
// - corrected single recoverable, others unrecoverable
// - read data bad unrecoverable, write fatal
// - snoop errors fatal when Modified or when CF_SNOOP_FE is set, else recoverable
// - every check except snoop enabled independently by configuration
// - unrecoverable raises machine check, vector 18
// - central agent reports via interrupt or init
module bus_error_checker
  import bus_integrity_pkg::*;
#(
  parameter logic [CFG_W-1:0] CFG_POWER_ON = 8'hBF,
  parameter int               RETRY_MAX    = RETRY_LIMIT
)(
  bus_link_if.agent                  bus,
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic                       irq,
  input  wire logic                  req_valid,
  input  wire logic [CMD_W-1:0]      req_cmd,
  input  wire logic [ADDR_HI:ADDR_LO] req_addr,
  input  wire logic [1:0]            req_size,
  input  wire logic [DATA_W-1:0]     req_wdata,
  input  wire logic [1:0]            corrupt_n,
  output logic                       req_ready,
  output logic                       done,
  output logic                       done_error,
  output logic [DATA_W-1:0]          done_rdata,
  input  wire logic                  snoop_err,
  input  wire line_state_t           snoop_state,
  output logic                       machine_check,
  output logic [7:0]                 mc_vector,
  output logic                       arbiter_reset,
  output logic                       pipeline_reset
);
  if (RETRY_MAX < 1 || RETRY_MAX > 2) begin : bad_retry
    $error("RETRY_MAX must be 1 or 2");
  end

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_REQ = 5'b00010, S_ERR = 5'b00100,
    S_DATA = 5'b01000, S_RESP = 5'b10000
  } ini_state_t;

  ini_state_t        state;
  logic [2:0]        cnt;
  logic [1:0]        retry;
  logic [1:0]        corrupt_q;
  logic              err_pend;
  logic [CFG_W-1:0]  cfg;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   enable;
  logic [ST_W-1:0]   set;
  logic [ST_W-1:0]   clear_pulse;
  logic [CHK_W-1:0]  syn_log;
  logic [DATA_W-1:0] wdata_q;
  logic              wr_pend;
  logic [7:0]        addr_q;

  // ----------------------------------------------------------------------
  // request phase drive
  // ----------------------------------------------------------------------
  wire is_write = bus.request_command[CMD_WRITE_BIT];
  wire ap_flip  = retry < corrupt_q;
  wire hi_par   = (bus.address_size_code == ASZ_4G) ?
                  ^bus.address[AP_HI_TOP_4G:AP_HI_BOT] :
                  ^bus.address[ADDR_HI:AP_HI_BOT];
  assign bus.request_strobe     = (state == S_REQ);
  assign bus.request_parity     = ^{bus.request_strobe, bus.request_command};
  assign bus.address_parity     = {hi_par, ^bus.address[AP_LO_TOP:ADDR_LO] ^ ap_flip};
  assign bus.wr_valid           = (state == S_DATA);
  assign bus.wr_data            = wdata_q;
  assign bus.wr_data_check_bits = ecc_gen(wdata_q);
  assign req_ready              = (state == S_IDLE);

  // ----------------------------------------------------------------------
  // checks and classification
  // ----------------------------------------------------------------------
  wire rp_bad  = cfg[CF_RP_CHK] &
                 ^{bus.request_strobe, bus.request_command, bus.request_parity};
  wire ap_bad  = cfg[CF_AP_CHK] &
                 ((^{bus.address[AP_LO_TOP:ADDR_LO], bus.address_parity[0]}) |
                  (hi_par ^ bus.address_parity[1]));
  wire req_err = bus.request_strobe & (rp_bad | ap_bad) & cfg[CF_ADDRESS_ERROR_FLAG_DRV];
  wire at_err  = (state == S_ERR) && (cnt == ERR_PHASE);
  wire cancel  = at_err & bus.address_error_flag & cfg[CF_ADDRESS_ERROR_FLAG_OBS] & cfg[CF_ADDRESS_ERROR_FLAG_DRV];
  wire retry_ok = retry < 2'(RETRY_MAX);
  wire rsp_bad = cfg[CF_RSP_CHK] & ^{bus.response_status, bus.response_parity};
  wire rsp_in  = (state == S_RESP) && (bus.response_status != RS_IDLE);
  wire [CHK_W-1:0]  syn  = ecc_gen(bus.rd_data) ^ bus.rd_data_check_bits;
  wire [DATA_W-1:0] flip = ecc_flip(syn);
  wire rd_chk  = rsp_in & bus.rd_valid & cfg[CF_ECC] & (syn != '0);
  wire corr    = (^syn) & ((flip != '0) | ($countones(syn) == 1));
  wire snoop_fe = snoop_err & ((snoop_state == LINE_M) | cfg[CF_SNOOP_FE]);
  wire fatal_in = bus.oth_fatal;

  always_comb begin
    set               = '0;
    set[ST_ADDR_PAR]  = req_err;
    set[ST_RE]        = (cancel & retry_ok) | (rd_chk & corr) | (snoop_err & !snoop_fe);
    set[ST_UE]        = (cancel & !retry_ok) | (rd_chk & !corr);
    set[ST_RSP_PAR]   = rsp_bad;
    set[ST_FE]        = rsp_bad | snoop_fe | fatal_in;
    set[ST_DATA_CORR] = rd_chk & corr;
    set[ST_DATA_BAD]  = rd_chk & !corr;
    set[ST_SNOOP]     = snoop_err;
  end

  // ----------------------------------------------------------------------
  // initiator sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                 <= S_IDLE;
      cnt                   <= '0;
      retry                 <= '0;
      corrupt_q             <= '0;
      err_pend              <= 1'b0;
      wdata_q               <= '0;
      bus.request_command   <= '0;
      bus.address           <= '0;
      bus.address_size_code <= '0;
      done                  <= 1'b0;
      done_error            <= 1'b0;
      done_rdata            <= '0;
      arbiter_reset         <= 1'b0;
    end else begin
      done          <= 1'b0;
      done_error    <= 1'b0;
      arbiter_reset <= cancel;
      cnt           <= cnt + 3'h1;
      case (state)
        S_IDLE: begin
          if (req_valid) begin
            state                 <= S_REQ;
            retry                 <= '0;
            corrupt_q             <= corrupt_n;
            bus.request_command   <= req_cmd;
            bus.address           <= req_addr;
            bus.address_size_code <= req_size;
            wdata_q               <= req_wdata;
          end
        end
        S_REQ: begin
          state    <= S_ERR;
          cnt      <= 3'h1;
          err_pend <= req_err;
        end
        S_ERR: begin
          if (cancel) begin
            retry <= retry + 2'h1;
            if (retry_ok) state <= S_REQ;
            else begin
              state      <= S_IDLE;
              done       <= 1'b1;
              done_error <= 1'b1;
            end
          end else if (at_err) state <= is_write ? S_DATA : S_RESP;
        end
        S_DATA: state <= S_RESP;
        S_RESP: begin
          if (rsp_in) begin
            state      <= S_IDLE;
            done       <= 1'b1;
            done_error <= rd_chk & !corr;
            done_rdata <= (cfg[CF_ECC] && corr) ? bus.rd_data ^ flip : bus.rd_data;
          end
        end
        default: state <= S_IDLE;
      endcase
      if (set[ST_FE]) begin
        state <= S_IDLE;
        if (state != S_IDLE) begin
          done       <= 1'b1;
          done_error <= 1'b1;
        end
      end
    end
  end

  assign bus.dev_address_error_flag_out = 1'b1;
  assign bus.dev_address_error_flag_oe  = at_err & err_pend;

  // ----------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status           <= '0;
      syn_log          <= '0;
      machine_check    <= 1'b0;
      mc_vector        <= MC_VECTOR;
      pipeline_reset   <= 1'b0;
      bus.dev_fatal    <= 1'b0;
      bus.error_report <= 1'b0;
    end else begin
      // set wins over a same-cycle clear
      status           <= (status & ~clear_pulse) | set;
      if (rd_chk) syn_log <= syn;
      machine_check    <= set[ST_UE] & cfg[CF_MCE];
      bus.error_report <= set[ST_UE] & !cfg[CF_MCE];
      pipeline_reset   <= set[ST_FE];
      bus.dev_fatal    <= set[ST_FE] & !fatal_in;
    end
  end

  assign irq = |(status & enable);

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  wire             take     = hsel & hready & htrans[1];
  wire [7:0]       rd_addr  = haddr[7:0];
  wire [31:0]      rd_mux   =
    (rd_addr == OFS_CFG)    ? {24'h000000, cfg} :
    (rd_addr == OFS_STATUS) ? {24'h000000, status} :
    (rd_addr == OFS_ENABLE) ? {24'h000000, enable} :
    (rd_addr == OFS_LOG)    ? {22'h000000, retry, syn_log} : 32'h00000000;
  wire             wr_go    = wr_pend & hready;
  assign clear_pulse = (wr_go && addr_q == OFS_CLEAR) ? hwdata[ST_W-1:0] : '0;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q  <= '0;
      hrdata  <= '0;
      cfg     <= CFG_POWER_ON;
      enable  <= '0;
    end else begin
      if (hready) wr_pend <= take & hwrite;
      if (take) addr_q <= rd_addr;
      if (take && !hwrite) hrdata <= rd_mux;
      if (wr_go && addr_q == OFS_CFG) cfg <= hwdata[CFG_W-1:0];
      if (wr_go && addr_q == OFS_ENABLE) enable <= hwdata[ST_W-1:0];
    end
  end
endmodule : bus_error_checker
`default_nettype wire

// ===== bus_link_checker.sv
// Purpose: wire-level checks between the two agents
// Assumes: one clock; address errors cancel only while both agents observe
// Notes:   low address parity bit unchecked, the bench corrupts it on purpose
`timescale 1ns/1ns
`default_nettype none
module bus_link_checker import bus_integrity_pkg::*; (
  input wire logic                   hclk, hresetn, request_strobe, request_parity,
  input wire logic                   response_parity, wr_valid, address_error_flag, dev_fatal,
  input wire logic [CMD_W-1:0]       request_command,
  input wire logic [ADDR_HI:ADDR_LO] address,
  input wire logic [1:0]             address_size_code, address_parity,
  input wire logic [RS_W-1:0]        response_status
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------------
  // parity, framing and error handling
  // ----------------------------------------------------------------------
  a_req_parity_even: assert property (request_strobe |-> !(^{request_strobe,
    request_command, request_parity})) else $error("request parity odd");
  a_addr_hi_small: assert property (request_strobe && address_size_code == 2'h0
    |-> !(^{address[31:24], address_parity[1]})) else $error("high address parity odd");
  a_addr_hi_large: assert property (request_strobe && address_size_code == 2'h1
    |-> !(^{address[35:24], address_parity[1]})) else $error("wide address parity odd");
  a_strobe_gap: assert property (request_strobe |=> !request_strobe [*3])
    else $error("strobe inside error window");
  a_address_error_flag_in_phase: assert property ($rose(address_error_flag) |-> $past(request_strobe, 3))
    else $error("address error outside error phase");
  a_cancel_phases: assert property (address_error_flag |=> response_status == RS_IDLE
    && !wr_valid ##1 response_status == RS_IDLE) else $error("cancelled phases went on");
  a_wr_after_strobe: assert property (wr_valid |-> $past(request_strobe, 4)
    && request_command[CMD_WRITE_BIT]) else $error("write data out of place");
  a_rsp_fatal: assert property (^{response_status, response_parity} |-> ##[1:3] dev_fatal)
    else $error("response parity error not fatal");
  // the last scenario injects an address and a data fault together; c_address_error_flag marks three walks and c_fatal two
  c_write: cover property (request_strobe && request_command[CMD_WRITE_BIT]);
  c_address_error_flag: cover property ($rose(address_error_flag));
  c_fatal: cover property (dev_fatal);
endmodule : bus_link_checker
`default_nettype wire

// ===== bus_error_protection_checker_tb_top.sv
// Purpose: drives both agents through registers and requests
// Assumes: hreadyout is the only slave on the register bus
// Notes:   status is read and cleared after every scenario
`timescale 1ns/1ns
`default_nettype none
module bus_error_protection_checker_tb_top import bus_integrity_pkg::*; ;
  logic hclk, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq, req_valid = 0;
  logic req_ready, done, done_error, snoop_err = 0, inj_rsp_parity = 0, machine_check;
  logic arbiter_reset, pipeline_reset, wr_out_valid, nmi, soft_init, handler_sel = 0;
  logic address_error_flag_drive_en = 1, address_error_flag_observe_en = 1, central_nmi_en = 1, nmi_seen = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, corrupt_n = 0, req_size = 0;
  logic [2:0] hsize = 3'h2, seen;
  logic [4:0] req_cmd = 0;
  logic [7:0] mc_vector;
  logic [ADDR_HI:ADDR_LO] req_addr = 33'h1_2345_6789;
  logic [63:0] req_wdata = 64'hA5A5_0F0F_1234_5678, rd_source = 64'h0123_4567_89AB_CDEF;
  logic [63:0] inj_data_flip = 0, pass_mask = 0, done_rdata, wr_out_data;
  line_state_t snoop_state = LINE_I;
  int error_cnt = 0, samples_checked = 0;
  assign hready = hreadyout;
  always @(posedge hclk) if (nmi) nmi_seen <= 1'b1;
  bus_link_if bl ();
  bus_error_checker bus_error_checker_i (.bus(bl), .*);
  bus_far_agent bus_far_agent_i (.bus(bl), .*);
  bus_link_checker bus_link_checker_i (.hclk(hclk), .hresetn(hresetn),
    .request_strobe(bl.request_strobe), .request_parity(bl.request_parity),
    .response_parity(bl.response_parity), .wr_valid(bl.wr_valid), .dev_fatal(bl.dev_fatal),
    .address_error_flag(bl.address_error_flag), .request_command(bl.request_command),
    .address(bl.address), .address_size_code(bl.address_size_code),
    .address_parity(bl.address_parity), .response_status(bl.response_status));
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // bounded wait: k=0 ready, k=1 done; sampled mid-cycle, returns on the edge
  task automatic await(input int k);
    int n;
    for (n = 0; n < 100; n++) begin
      @(negedge hclk);
      if ((k ? done : hreadyout) === 1'b1) break;
    end
    seen = {pipeline_reset, machine_check, done_error};
    @(posedge hclk);
    if (n == 100) begin
      error_cnt++;
      print_verdict;
    end
  endtask : await
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    await(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    await(0);
    r = hrdata;
  endtask : ahb
  // enable holds only the unrecoverable bit, so irq follows it
  task automatic stat(input logic [7:0] e);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(r, e);
    chk(irq, e[1]);
    ahb(1'b1, OFS_CLEAR, 32'hFF);
  endtask : stat
  task automatic op(input logic [4:0] c, input logic [1:0] cn, input logic [63:0] f,
                    input logic de, input logic [7:0] e);
    req_cmd <= c;
    corrupt_n <= cn;
    inj_data_flip <= f;
    req_size <= req_size ^ 2'h1;
    req_valid <= 1'b1;
    @(posedge hclk);
    req_valid <= 1'b0;
    await(1);
    chk(seen, {e[2], e[1], de});
    if (!de) chk(c[0] ? wr_out_data : done_rdata, c[0] ? req_wdata : rd_source ^ (f & pass_mask));
    stat(e);
  endtask : op
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_CFG, 32'h0);
    chk(r, 32'hBF);
    ahb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    ahb(1'b1, OFS_ENABLE, 32'h2);
    op(5'h01, 2'h0, 64'h0, 1'b0, 8'h00);
    op(5'h00, 2'h0, 64'h8, 1'b0, 8'h21);
    op(5'h00, 2'h0, 64'h18, 1'b1, 8'h42);
    chk(nmi_seen, 1'b0);
    op(5'h00, 2'h1, 64'h0, 1'b0, 8'h09);
    chk(nmi_seen, 1'b1);
    op(5'h00, 2'h2, 64'h0, 1'b1, 8'h0B);
    chk(mc_vector, 8'h12);
    for (int i = 0; i < 4; i++) begin
      snoop_state <= line_state_t'(i);
      snoop_err <= 1'b1;
      @(posedge hclk);
      snoop_err <= 1'b0;
      repeat (3) @(posedge hclk);
      stat(i == 3 ? 8'h84 : 8'h81);
    end
    inj_rsp_parity <= 1'b1;
    op(5'h00, 2'h0, 64'h0, 1'b1, 8'h14);
    inj_rsp_parity <= 1'b0;
    // driver, observer and ECC off: address fault ignored, data passes raw
    ahb(1'b1, OFS_CFG, 32'h9C);
    address_error_flag_drive_en <= 1'b0;
    address_error_flag_observe_en <= 1'b0;
    pass_mask <= '1;
    op(5'h00, 2'h1, 64'h3, 1'b0, 8'h00);
    print_verdict;
  end
endmodule : bus_error_protection_checker_tb_top
`default_nettype wire
